// ### logic/brc_top.sv
/*
 Brown-out reset controller: combines power-on, brown-out, low-power
 brown-out and other reset sources, runs the power-up timer, gates
 start-up and wake on brown-out readiness, keeps reset cause flags and
 the identification words behind an APB slave.
 Assumes analog detectors drive asynchronous levels and the core reports
 sleep as a level; other reset sources are synchronous to pclk.
*/
// Decided for this implementation: the register offsets and register access over APB.
//////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Read-only 14-bit part identification word, writes ignored.
// - Read-only 14-bit revision word, top two bits read 10.
// - Reset on power-on, brown-outs, pin, watchdog, instruction, stack, prog exit.
// - Enabled power-up timer lengthens reset after power-on or brown-out.
// - Active brown-out with supply below level holds reset.
// - Two-bit mode: always on, off in sleep, software, always off.
// - One configuration bit picks the brown-out trip level.
// - Brown-out only after filter time; then clear brown-out flag.
// - Mode 11 keeps brown-out active always, sleep included.
// - Always-on mode never delays wake from sleep.
// - Modes 11 and 10 delay start-up until ready and supply good.
// - Mode 10 active awake, disabled in sleep.
// - Mode 10 delays wake until ready and supply good.
// - Mode 01 follows software enable bit; sleep does not change it.
// - Mode 01 wake skips wait only if enable clear and no power reset.
// - Read-only ready flag; protection starts once ready.
// - Mode 00 always disabled, software enable ignored.
// - Disabled brown-out lets execution begin immediately.
// - Low-power detector trip holds reset and clears brown-out flag.
// - Mode 10 low-power trip holds reset and re-arms power-on reset.
// - Own enable bit for low-power detector, disabled when erased.
// - Low-power and main brown-out requests are ORed into one.
// - Power-up timer starts after both resets release, 64 ms.
//////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module brc_top #(
	parameter int PUT_CYCLES = brc_pkg::PUT_CYC
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [brc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire brc_pkg::brc_det_t          det,
	input  wire brc_pkg::brc_src_t          src,
	input  wire logic                       sleep_mode,
	output logic                            core_reset_n,
	output logic                            cpu_run,
	output logic                            bor_enable,
	output logic                            bor_level_sel,
	output logic                            low_power_supply_monitor_enable_enable
);

	localparam int PUT_W = $clog2(PUT_CYCLES + 1);

	//////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == brc_pkg::OFS_PART) || (a == brc_pkg::OFS_REV) ||
			(a == brc_pkg::OFS_CFG) || (a == brc_pkg::OFS_CTRL) ||
			(a == brc_pkg::OFS_STAT);
	endfunction

	function automatic logic bor_on(input logic [1:0] mode,
		input logic asleep, input logic sb);
		case (mode)
			brc_pkg::MODE_ON:    bor_on = 1'b1;
			brc_pkg::MODE_NOSLP: bor_on = !asleep;
			brc_pkg::MODE_SW:    bor_on = sb;
			default:             bor_on = 1'b0;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Declarations

	brc_pkg::brc_cfg_t   cfg_q;
	brc_pkg::brc_stat_t  stat_q;
	brc_pkg::brc_stat_t  stat_d;
	brc_pkg::brc_det_t   det_s;
	brc_pkg::brc_state_t state_q;
	brc_pkg::brc_state_t state_d;
	logic                sb_q;
	logic [PUT_W-1:0]    put_q;
	logic [1:0]          rel_q;
	logic                pwr_rst_q;
	logic [31:0]         rd_d;
	logic                wr_en;
	logic                setup;
	logic                arst_n;
	logic                asleep;
	logic                bor_act;
	logic                bor_trip;
	logic                lp_trip;
	logic                bor_any;
	logic                por_evt;
	logic                other_rst;
	logic                sync_hold;
	logic                supply_ok;
	logic                start_wait;
	logic                wake_wait;

	//////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	assign pready  = 1'b1;
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && pstrb[0] &&
		addr_hit(paddr);
	assign pslverr = psel && penable && !addr_hit(paddr);

	always_comb
	begin
		rd_d = '0;
		case (paddr)
			brc_pkg::OFS_PART: rd_d[brc_pkg::ID_W-1:0] = brc_pkg::PART_CODE;
			brc_pkg::OFS_REV:
				rd_d[brc_pkg::ID_W-1:0] = {brc_pkg::REV_TOP, brc_pkg::REV_LOW};
			brc_pkg::OFS_CFG:  rd_d[brc_pkg::CFG_W-1:0] = cfg_q;
			brc_pkg::OFS_CTRL:
			begin
				rd_d[brc_pkg::CTRL_SB_BIT] = sb_q;
				rd_d[brc_pkg::CTRL_RDY_BIT] = det_s.bor_ready;
			end
			brc_pkg::OFS_STAT: rd_d[brc_pkg::STAT_W-1:0] = stat_q;
			default:           rd_d = '0;
		endcase
	end

	// Read data sampled in setup, stable through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (setup && !pwrite)
			prdata <= rd_d;
	end

	//////////////////////////////////////////////////////////////////////
	// Configuration and software control

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_q <= brc_pkg::CFG_RST;
		else if (wr_en && paddr == brc_pkg::OFS_CFG)
			cfg_q <= pwdata[brc_pkg::CFG_W-1:0];
	end

	// sleep leaves the enable bit alone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sb_q <= brc_pkg::SB_RST;
		else if (wr_en && paddr == brc_pkg::OFS_CTRL)
			sb_q <= pwdata[brc_pkg::CTRL_SB_BIT];
	end

	//////////////////////////////////////////////////////////////////////
	// Detector inputs

	brc_sync #(
		.W (brc_pkg::DET_W)
	) u_det_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (det),
		.q       (det_s)
	);

	assign asleep = (state_q == brc_pkg::ST_SLEEP);

	assign bor_act = bor_on(cfg_q.mode, asleep, sb_q);

	assign bor_level_sel = cfg_q.level;
	assign bor_enable    = bor_act;
	assign low_power_supply_monitor_enable_enable  = cfg_q.lp_en;

	brc_bor_filter u_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.armed   (bor_act && det_s.bor_ready),
		.low_s   (det_s.bor_low),
		.trip_q  (bor_trip)
	);

	assign lp_trip = cfg_q.lp_en && det_s.low_power_supply_monitor_enable_low;
	assign bor_any = bor_trip || lp_trip;
	// mode 10 low-power trip re-arms power-on
	assign por_evt = det_s.por_low ||
		(lp_trip && cfg_q.mode == brc_pkg::MODE_NOSLP);
	assign other_rst = src.ext || src.wdt || src.instr || src.stkovf ||
		src.stkunf || src.prog_exit;
	assign sync_hold = por_evt || bor_any || other_rst;
	assign supply_ok = det_s.bor_ready && !det_s.bor_low;

	//////////////////////////////////////////////////////////////////////
	// Reset cause flags

	always_comb
	begin
		stat_d = stat_q;
		if (wr_en && paddr == brc_pkg::OFS_STAT)
			stat_d = pwdata[brc_pkg::STAT_W-1:0];
		// Hardware events win over a software write
		if (por_evt)
			stat_d = brc_pkg::STAT_RST;
		if (bor_any)
			stat_d.bor_n = 1'b0;
		if (src.ext)
			stat_d.rmclr_n = 1'b0;
		if (src.wdt)
			stat_d.rwdt_n = 1'b0;
		if (src.instr)
			stat_d.ri_n = 1'b0;
		if (src.stkovf)
			stat_d.stkovf = 1'b1;
		if (src.stkunf)
			stat_d.stkunf = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_q <= brc_pkg::STAT_RST;
		else
			stat_q <= stat_d;
	end

	// Last reset came from power-on or brown-out
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwr_rst_q <= 1'b1;
		else if (por_evt || bor_any)
			pwr_rst_q <= 1'b1;
		else if (other_rst)
			pwr_rst_q <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////
	// Start-up and wake gating

	// wait in modes 11 and 10
	// ready before run when forced on
	always_comb
	begin
		case (cfg_q.mode)
			brc_pkg::MODE_ON:    start_wait = 1'b1;
			brc_pkg::MODE_NOSLP: start_wait = 1'b1;
			brc_pkg::MODE_SW:    start_wait = sb_q || pwr_rst_q;
			default:             start_wait = 1'b0;
		endcase
	end

	// no wake delay when always on
	always_comb
	begin
		case (cfg_q.mode)
			brc_pkg::MODE_NOSLP: wake_wait = 1'b1;
			brc_pkg::MODE_SW:    wake_wait = sb_q || pwr_rst_q;
			default:             wake_wait = 1'b0;
		endcase
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			brc_pkg::ST_HOLD:
				if (!sync_hold)
					state_d = (cfg_q.put_en && pwr_rst_q) ?
						brc_pkg::ST_PUT : brc_pkg::ST_BORWAIT;
			brc_pkg::ST_PUT:
				if (put_q == PUT_W'(PUT_CYCLES - 1))
					state_d = brc_pkg::ST_BORWAIT;
			brc_pkg::ST_BORWAIT:
				if (!start_wait || !bor_act || supply_ok)
					state_d = brc_pkg::ST_RUN;
			brc_pkg::ST_RUN:
				if (sleep_mode)
					state_d = brc_pkg::ST_SLEEP;
			brc_pkg::ST_SLEEP:
				if (!sleep_mode)
					state_d = wake_wait ?
						brc_pkg::ST_WAKEWAIT : brc_pkg::ST_RUN;
			// Disabled detector would never report ready
			brc_pkg::ST_WAKEWAIT:
				if (supply_ok || !bor_act)
					state_d = brc_pkg::ST_RUN;
			default:
				state_d = brc_pkg::ST_HOLD;
		endcase
		if (sync_hold)
			state_d = brc_pkg::ST_HOLD;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= brc_pkg::ST_HOLD;
		else
			state_q <= state_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			put_q <= '0;
		else if (state_q != brc_pkg::ST_PUT)
			put_q <= '0;
		else
			put_q <= put_q + 1'b1;
	end

	assign cpu_run = (state_q == brc_pkg::ST_RUN);

	//////////////////////////////////////////////////////////////////////
	// Core reset output

	// Raw detectors bypass the synchroniser only to assert reset
	assign arst_n = presetn && !det.por_low &&
		!(cfg_q.lp_en && det.low_power_supply_monitor_enable_low);

	always_ff @(posedge pclk or negedge arst_n)
	begin
		if (!arst_n)
			rel_q <= '0;
		else
			rel_q <= {rel_q[0], !sync_hold &&
				state_q != brc_pkg::ST_HOLD && state_q != brc_pkg::ST_PUT};
	end

	assign core_reset_n = rel_q[1];

endmodule

// ### logic/brc_pkg.sv
/*
 Shared constants and types of the brown-out reset controller: register
 offsets, field layouts, reset values, mode codes, timing and states.
 Assumes a 250 MHz APB clock and 32-bit APB data.
*/
package brc_pkg;

	// Register map, byte addresses
	localparam int          ADDR_W   = 12;
	localparam logic [11:0] OFS_PART = 12'h000;
	localparam logic [11:0] OFS_REV  = 12'h004;
	localparam logic [11:0] OFS_CFG  = 12'h008;
	localparam logic [11:0] OFS_CTRL = 12'h00C;
	localparam logic [11:0] OFS_STAT = 12'h010;

	// Identification, values arbitrary
	localparam logic [13:0] PART_CODE = 14'h0A5A;
	localparam logic [11:0] REV_LOW   = 12'h001;
	localparam logic [1:0]  REV_TOP   = 2'h2;
	localparam int          ID_W      = 14;

	// Brown-out mode field codes
	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_SW    = 2'h1;
	localparam logic [1:0] MODE_NOSLP = 2'h2;
	localparam logic [1:0] MODE_ON    = 2'h3;

	// Configuration register
	typedef struct packed {
		logic       put_en;
		logic       lp_en;
		logic       level;
		logic [1:0] mode;
	} brc_cfg_t;
	localparam int       CFG_W   = 5;
	localparam brc_cfg_t CFG_RST = 5'h07;

	// Control register fields
	localparam int   CTRL_SB_BIT  = 7;
	localparam int   CTRL_RDY_BIT = 0;
	localparam logic SB_RST       = 1'b1;

	// Power control status register
	typedef struct packed {
		logic stkovf;
		logic stkunf;
		logic rwdt_n;
		logic rmclr_n;
		logic ri_n;
		logic por_n;
		logic bor_n;
	} brc_stat_t;
	localparam int        STAT_W   = 7;
	localparam brc_stat_t STAT_RST = 7'h1C;

	// Analog detector outputs, asynchronous
	typedef struct packed {
		logic por_low;
		logic bor_low;
		logic bor_ready;
		logic low_power_supply_monitor_enable_low;
	} brc_det_t;
	localparam int DET_W = 4;

	// Other reset sources, synchronous levels
	typedef struct packed {
		logic ext;
		logic wdt;
		logic instr;
		logic stkovf;
		logic stkunf;
		logic prog_exit;
	} brc_src_t;

	// Timing
	localparam int CLK_MHZ     = 250;
	localparam int PUT_MS      = 64;
	localparam int PUT_CYC     = PUT_MS * CLK_MHZ * 1000;
	localparam int BOR_FILT_NS = 1000;
	localparam int FILT_CYC    = (BOR_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int FILT_W      = $clog2(FILT_CYC + 1);

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_PUT,
		ST_BORWAIT,
		ST_RUN,
		ST_SLEEP,
		ST_WAKEWAIT
	} brc_state_t;

endpackage

// ### logic/brc_sync.sv
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; no word coherence across bits.
*/
`timescale 1ns/1ns
module brc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// ### logic/brc_bor_filter.sv
/*
 Noise filter for the brown-out detector: trips only when the synchronised
 low-supply level lasts longer than the filter count while armed.
 Assumes low_s is already synchronous to pclk.
*/
`timescale 1ns/1ns
module brc_bor_filter (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic armed,
	input  wire logic low_s,
	output logic      trip_q
);

	logic [brc_pkg::FILT_W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (!(armed && low_s))
			cnt_q <= '0;
		else if (cnt_q != brc_pkg::FILT_W'(brc_pkg::FILT_CYC))
			cnt_q <= cnt_q + 1'b1;
	end

	// Strictly longer than the filter time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trip_q <= 1'b0;
		else
			trip_q <= armed && low_s &&
				(cnt_q == brc_pkg::FILT_W'(brc_pkg::FILT_CYC));
	end

endmodule

// ### tb/brc_properties.sv
/*
 Port checker for the brown-out reset controller.
 Assumes it is bound to brc_top and sees only its ports.
*/
`timescale 1ns/1ns
module brc_checker (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic [11:0]       paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire brc_pkg::brc_det_t det,
	input wire brc_pkg::brc_src_t src,
	input wire logic              sleep_mode,
	input wire logic              core_reset_n,
	input wire logic              cpu_run,
	input wire logic              bor_enable,
	input wire logic              bor_level_sel,
	input wire logic              low_power_supply_monitor_enable_enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	brc_pkg::brc_cfg_t cfg_q;
	logic              rd_acc;
	// Shadow of the configuration register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cfg_q <= brc_pkg::CFG_RST;
		else if (psel && penable && pwrite && pstrb[0]
			&& paddr == brc_pkg::OFS_CFG)
			cfg_q <= pwdata[4:0];
	assign rd_acc = psel && penable && !pwrite;
	a_por_holds: assert property (det.por_low |-> !core_reset_n)
		else $error("reset open in power-on");
	a_low_power_supply_monitor_enable_holds: assert property (low_power_supply_monitor_enable_enable && det.low_power_supply_monitor_enable_low |-> !core_reset_n)
		else $error("reset open in low-power trip");
	a_src_resets: assert property (|src |-> ##[1:4] !core_reset_n)
		else $error("source did not reset");
	a_run_stops: assert property ($fell(core_reset_n) |-> ##[0:5] !cpu_run)
		else $error("core kept running in reset");
	a_part_read: assert property (rd_acc && paddr == brc_pkg::OFS_PART
		|-> prdata == {18'h0_0000, brc_pkg::PART_CODE})
		else $error("part word wrong");
	a_rev_read: assert property (rd_acc && paddr == brc_pkg::OFS_REV
		|-> prdata[31:12] == 20'h0_0002)
		else $error("revision top bits wrong");
	a_off_mode: assert property (cfg_q.mode == brc_pkg::MODE_OFF |-> !bor_enable)
		else $error("detector on in off mode");
	a_on_mode: assert property (cfg_q.mode == brc_pkg::MODE_ON |-> bor_enable)
		else $error("detector off in on mode");
	a_level_sel: assert property (bor_level_sel == cfg_q.level)
		else $error("trip level select wrong");
	a_lp_enable: assert property (low_power_supply_monitor_enable_enable == cfg_q.lp_en)
		else $error("low-power enable wrong");
	c_por: cover property (det.por_low);
	c_src: cover property (|src);
	c_run: cover property ($rose(cpu_run));
endmodule
bind brc_top brc_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable,
	.pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .det, .src,
	.sleep_mode, .core_reset_n, .cpu_run, .bor_enable, .bor_level_sel,
	.low_power_supply_monitor_enable_enable);

// ### tb/brc_det_model.sv
/*
 Behavioural analog detectors: power-on, brown-out, low-power brown-out.
 Assumes vdd is an abstract supply code driven by the bench.
*/
`timescale 1ns/1ns
module brc_det_model #(
	parameter int POR_TRIP = 10,
	parameter int LP_TRIP  = 20,
	parameter int LO_TRIP  = 24,
	parameter int HI_TRIP  = 27
) (
	input wire logic        pclk,
	input wire logic [7:0]  vdd,
	input wire logic [7:0]  rdy_cyc,
	input wire logic        bor_enable,
	input wire logic        bor_level_sel,
	input wire logic        low_power_supply_monitor_enable_enable,
	output brc_pkg::brc_det_t det
);
	logic [7:0] rdy_cnt = 8'h00;
	always @(posedge pclk)
		if (!bor_enable)
			rdy_cnt <= 8'h00;
		else if (rdy_cnt < rdy_cyc)
			rdy_cnt <= rdy_cnt + 8'h01;
	always_comb
	begin
		det.por_low = vdd < POR_TRIP;
		det.bor_ready = bor_enable && rdy_cnt >= rdy_cyc;
		det.bor_low = det.bor_ready && vdd < (bor_level_sel ? HI_TRIP : LO_TRIP);
		det.low_power_supply_monitor_enable_low = low_power_supply_monitor_enable_enable && vdd < LP_TRIP;
	end
endmodule

// ### tb/brc_top_tb.sv
/*
 Self-checking bench for brc_top with detector model.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ns
module brc_top_tb;
	localparam int PUT = 20;
	logic              pclk, presetn, psel, penable, pwrite, sleep_mode;
	logic              pready, pslverr, core_reset_n, cpu_run, err, low_seen;
	logic              bor_enable, bor_level_sel, low_power_supply_monitor_enable_enable;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic [7:0]        vdd, rdy_cyc;
	logic [1:0]        modes [3];
	brc_pkg::brc_det_t det;
	brc_pkg::brc_src_t src;
	int                err_count, cmp_count, lat;
	brc_top #(.PUT_CYCLES(PUT)) u_dut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .det,
		.src, .sleep_mode, .core_reset_n, .cpu_run, .bor_enable,
		.bor_level_sel, .low_power_supply_monitor_enable_enable);
	brc_det_model u_det (.pclk, .vdd, .rdy_cyc, .bor_enable, .bor_level_sel,
		.low_power_supply_monitor_enable_enable, .det);
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (core_reset_n === 1'b0)
			low_seen = 1'b1;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wait_run(output int n);
		n = 0;
		while (!(cpu_run === 1'b1 && core_reset_n === 1'b1) && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000)
		begin
			err_count++;
			$display("[ERR] %0t core never resumed running", $time);
			print_verdict();
		end
	endtask
	task dip(input logic [7:0] v, input int n, input logic exp);
		low_seen = 1'b0;
		vdd <= v;
		repeat (n) @(posedge pclk);
		vdd <= 8'h21;
		repeat (10) @(posedge pclk);
		check(32'(low_seen), 32'(exp));
		wait_run(lat);
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, sleep_mode} = 5'h00;
		paddr = '0;
		pwdata = '0;
		src = '0;
		pstrb = 4'hF;
		vdd = 8'h21;
		rdy_cyc = 8'h28;
		modes = '{brc_pkg::MODE_ON, brc_pkg::MODE_NOSLP, brc_pkg::MODE_SW};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_run(lat);
		check(32'(lat >= 40), 32'h0000_0001);
		apb(1'b1, brc_pkg::OFS_PART, 32'h0000_0000);
		apb(1'b0, brc_pkg::OFS_PART, 32'h0000_0000);
		check(rd, {18'h0_0000, brc_pkg::PART_CODE});
		apb(1'b0, brc_pkg::OFS_REV, 32'h0000_0000);
		check(32'(rd[31:12]), 32'h0000_0002);
		apb(1'b0, brc_pkg::OFS_CFG, 32'h0000_0000);
		check(rd, 32'(brc_pkg::CFG_RST));
		apb(1'b0, 12'hFFC, 32'h0000_0000);
		check({31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b1, brc_pkg::OFS_STAT, 32'h0000_007F);
		dip(8'h19, 200, 1'b0);
		dip(8'h19, 400, 1'b1);
		apb(1'b0, brc_pkg::OFS_STAT, 32'h0000_0000);
		check(32'(rd[0]), 32'h0000_0000);
		apb(1'b1, brc_pkg::OFS_CFG, 32'h0000_0003);
		dip(8'h19, 400, 1'b0);
		apb(1'b1, brc_pkg::OFS_CFG, 32'h0000_0000);
		dip(8'h0F, 400, 1'b0);
		apb(1'b1, brc_pkg::OFS_CFG, 32'h0000_0008);
		apb(1'b1, brc_pkg::OFS_STAT, 32'h0000_007F);
		dip(8'h0F, 20, 1'b1);
		apb(1'b0, brc_pkg::OFS_STAT, 32'h0000_0000);
		check(32'(rd[0]), 32'h0000_0000);
		for (int i = 0; i < 6; i++)
		begin
			low_seen = 1'b0;
			src <= brc_pkg::brc_src_t'(6'h01 << i);
			repeat (2) @(posedge pclk);
			src <= '0;
			repeat (6) @(posedge pclk);
			wait_run(lat);
			check(32'({low_seen, 1'(lat < 40)}), 32'h0000_0003);
		end
		apb(1'b1, brc_pkg::OFS_CFG, 32'h0000_0014);
		dip(8'h05, 10, 1'b1);
		check(32'(lat + 10 >= PUT), 32'h0000_0001);
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, brc_pkg::OFS_CFG, {30'h0000_0000, modes[k]});
			sleep_mode <= 1'b1;
			repeat (10) @(posedge pclk);
			sleep_mode <= 1'b0;
			wait_run(lat);
			check(32'(lat >= 40), 32'(k == 1));
		end
		apb(1'b0, brc_pkg::OFS_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0081);
		apb(1'b1, brc_pkg::OFS_CTRL, 32'h0000_0000);
		check(32'(bor_enable), 32'h0000_0000);
		sleep_mode <= 1'b1;
		repeat (10) @(posedge pclk);
		sleep_mode <= 1'b0;
		wait_run(lat);
		check(32'(lat < 40), 32'h0000_0001);
		print_verdict();
	end
endmodule
